// ==== hdl/sfs_pkg.sv ====
// Shared constants and types for the serial flash status register block and its host
package sfs_pkg;
	// ****************************************
	// Command opcodes
	// ****************************************
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_VWREN = 8'h50;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_WRSR3 = 8'h11;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_RDSR3 = 8'h15;
	localparam logic [7:0] OP_RSTEN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	// ****************************************
	// Status field positions
	// ****************************************
	localparam int SR1_REG_LOCK_SELECT_LOW = 7;
	localparam int SR1_SEC = 6;
	localparam int SR1_TB = 5;
	localparam int SR1_BP_HI = 4;
	localparam int SR1_BP_LO = 2;
	localparam int SR2_CMP = 6;
	localparam int SR2_QE = 1;
	localparam int SR2_REG_LOCK_SELECT_HIGH = 0;
	localparam int SR3_WRAP_HI = 6;
	localparam int SR3_WRAP_LO = 5;
	localparam int SR3_WRAP_OFF = 4;
	// ****************************************
	// Reset values and write masks
	// ****************************************
	localparam logic [7:0] SR1_NV_RST = 8'h00;
	localparam logic [7:0] SR2_NV_RST = 8'h04;
	localparam logic [7:0] SR3_RST = 8'h70;
	localparam logic [7:0] SR1_WR_MASK = 8'hFC;
	localparam logic [7:0] SR2_WR_MASK = 8'h43;
	localparam logic [7:0] SR2_OTP_MASK = 8'h3C;
	localparam logic [7:0] SR2_SH_MASK = 8'h42;
	localparam logic [7:0] SR3_WR_MASK = 8'h7F;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 20;
	localparam int NV_WRITE_NS = 10000;
	localparam logic [15:0] NV_WRITE_CYC = 16'((NV_WRITE_NS + CLK_NS - 1) / CLK_NS);
	localparam int SCLK_HALF_NS = 80;
	localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_HALF_NS / CLK_NS);
	localparam logic [3:0] CS_IDLE_CYC = 4'h8;
	// ****************************************
	// Host register map
	// ****************************************
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_TXDATA = 5'h04;
	localparam logic [4:0] REG_STATUS = 5'h08;
	localparam logic [4:0] REG_PINS = 5'h0C;
	localparam int CTRL_GO = 31;
	localparam int CTRL_READ = 10;
	localparam int CTRL_NTX_HI = 9;
	localparam int CTRL_NTX_LO = 8;
	// ****************************************
	// State types
	// ****************************************
	typedef enum logic [3:0] {
		SFS_OP_IDLE = 4'b0001,
		SFS_OP_NVW = 4'b0010,
		SFS_OP_ARR = 4'b0100,
		SFS_OP_SUSP = 4'b1000
	} sfs_op_e;
	typedef enum logic [3:0] {
		SFS_H_IDLE = 4'b0001,
		SFS_H_SEL = 4'b0010,
		SFS_H_SHIFT = 4'b0100,
		SFS_H_DESEL = 4'b1000
	} sfs_hst_e;
endpackage

// ==== hdl/sfs_link_if.sv ====
// Serial link between flash host and flash status device
`timescale 1ns/1ns
interface sfs_link_if;
	logic sclk;
	logic cs_n;
	logic [3:0] h_o;
	logic [3:0] h_oe;
	logic [3:0] d_o;
	logic [3:0] d_oe;
	logic [3:0] dq;
	// Resolved data lines; undriven lines float high via pull-ups
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			dq[i] = h_oe[i] ? h_o[i] : (d_oe[i] ? d_o[i] : 1'b1);
		end
	end
	modport host (output sclk, output cs_n, output h_o, output h_oe, input dq);
	modport device (input sclk, input cs_n, input dq, output d_o, output d_oe);
endinterface

// ==== hdl/sfs_dev.sv ====
// Flash status register device end: command decode, protection and status flags
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module sfs_dev (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Serial link
	sfs_link_if.device lnk,
	// Array engine side
	input wire logic op_req,
	input wire logic op_done,
	input wire logic suspend_req,
	input wire logic resume_req,
	output logic op_granted,
	output logic op_refused,
	// Status and configuration view
	output logic [7:0] status_reg_one,
	output logic [7:0] status_reg_two,
	output logic [7:0] status_reg_three,
	output logic quad_io_on,
	output logic protect_granularity,
	output logic protect_from_low_end,
	output logic [2:0] protect_range,
	output logic protect_none,
	output logic invert_protect_map,
	output logic [6:0] wrap_bytes,
	output logic wrap_enable
);
	// ****************************************
	// State
	// ****************************************
	logic [3:0] s1_q, s2_q;
	logic sclk_prev_q, cs_prev_q;
	logic [7:0] shift_q, shift_d, cmd_q, cmd_d, d1_q, d1_d, d2_q, d2_d;
	logic [2:0] bit_q, bit_d;
	logic [1:0] byte_q, byte_d;
	logic [7:0] tx_q, tx_d;
	logic out_q, out_d, rd_act_q, rd_act_d;
	logic [7:0] nv1_q, nv1_d, nv2_q, nv2_d, sh1_q, sh1_d, sh2_q, sh2_d, sr3_q, sr3_d;
	logic [7:0] pend1_q, pend1_d, pend2_q, pend2_d;
	logic pend_two_q, pend_two_d;
	logic write_latch_q, write_latch_d, vol_en_q, vol_en_d, arm_q, arm_d;
	logic [15:0] cnt_q, cnt_d;
	sfs_pkg::sfs_op_e op_q, op_d;
	logic gnt_q, gnt_d, ref_q, ref_d;
	logic sclk_s, cs_s, mosi_s, wp_s;
	logic sclk_rise, sclk_fall, cs_fall, cs_rise;
	logic busy, paused_flag, locked, cmd_done;
	logic [7:0] rx_byte;

	// Pin synchronisers: sclk, cs_n, data line 0, data line 2 (write protect)
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= 4'h3;
			s2_q <= 4'h3;
			sclk_prev_q <= 1'b1;
			cs_prev_q <= 1'b1;
		end else begin
			s1_q <= {lnk.dq[2], lnk.dq[0], lnk.cs_n, lnk.sclk};
			s2_q <= s1_q;
			sclk_prev_q <= s2_q[0];
			cs_prev_q <= s2_q[1];
		end
	end
	assign sclk_s = s2_q[0];
	assign cs_s = s2_q[1];
	assign mosi_s = s2_q[2];
	assign wp_s = s2_q[3];
	assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_s;
	assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_s;
	assign cs_fall = ~cs_s & cs_prev_q;
	assign cs_rise = cs_s & ~cs_prev_q;

	// Flags and protection decode
	assign busy = (op_q == sfs_pkg::SFS_OP_NVW) || (op_q == sfs_pkg::SFS_OP_ARR);
	assign paused_flag = (op_q == sfs_pkg::SFS_OP_SUSP);
	// Pin only matters with lock select low set and quad mode off; lock select high locks all
	assign locked = nv2_q[sfs_pkg::SR2_REG_LOCK_SELECT_HIGH]
		| (nv1_q[sfs_pkg::SR1_REG_LOCK_SELECT_LOW] & ~wp_s & ~sh2_q[sfs_pkg::SR2_QE]);
	assign cmd_done = (byte_q != 2'h0) && (bit_q == 3'h0);
	assign rx_byte = {shift_q[6:0], mosi_s};

	// Readable views; busy, latch and paused come only from control logic
	assign status_reg_one = {sh1_q[7:2], write_latch_q, busy};
	assign status_reg_two = {paused_flag, sh2_q[sfs_pkg::SR2_CMP], nv2_q[5:2],
		sh2_q[sfs_pkg::SR2_QE], nv2_q[sfs_pkg::SR2_REG_LOCK_SELECT_HIGH]};
	assign status_reg_three = sr3_q;
	// Block protection and quad behaviour come from the shadows, never from the stored cells
	assign quad_io_on = sh2_q[sfs_pkg::SR2_QE];
	assign invert_protect_map = sh2_q[sfs_pkg::SR2_CMP];
	assign protect_granularity = sh1_q[sfs_pkg::SR1_SEC];
	assign protect_from_low_end = sh1_q[sfs_pkg::SR1_TB];
	assign protect_range = sh1_q[sfs_pkg::SR1_BP_HI:sfs_pkg::SR1_BP_LO];
	assign protect_none = (protect_range == 3'h0);
	assign wrap_bytes = 7'(8'h08 << sr3_q[sfs_pkg::SR3_WRAP_HI:sfs_pkg::SR3_WRAP_LO]);
	assign wrap_enable = ~sr3_q[sfs_pkg::SR3_WRAP_OFF];
	assign op_granted = gnt_q;
	assign op_refused = ref_q;
	assign lnk.d_o = {2'b00, out_q, 1'b0};
	assign lnk.d_oe = {2'b00, rd_act_q, 1'b0};

	// Next-state logic for the serial front end, registers and operation sequencer
	always_comb begin
		shift_d = shift_q;
		cmd_d = cmd_q;
		d1_d = d1_q;
		d2_d = d2_q;
		bit_d = bit_q;
		byte_d = byte_q;
		tx_d = tx_q;
		out_d = out_q;
		rd_act_d = rd_act_q;
		nv1_d = nv1_q;
		nv2_d = nv2_q;
		sh1_d = sh1_q;
		sh2_d = sh2_q;
		sr3_d = sr3_q;
		pend1_d = pend1_q;
		pend2_d = pend2_q;
		pend_two_d = pend_two_q;
		write_latch_d = write_latch_q;
		vol_en_d = vol_en_q;
		arm_d = arm_q;
		cnt_d = cnt_q;
		op_d = op_q;
		gnt_d = 1'b0;
		ref_d = 1'b0;
		// Receive: sample on rising sclk, MSB first
		if (cs_fall) begin
			bit_d = 3'h0;
			byte_d = 2'h0;
		end else if (sclk_rise) begin
			shift_d = rx_byte;
			bit_d = bit_q + 3'h1;
			if (bit_q == 3'h7) begin
				if (byte_q != 2'h3) begin
					byte_d = byte_q + 2'h1;
				end
				case (byte_q)
					2'h0: begin
						cmd_d = rx_byte;
						rd_act_d = 1'b1;
						case (rx_byte)
							sfs_pkg::OP_RDSR1: tx_d = status_reg_one;
							sfs_pkg::OP_RDSR2: tx_d = status_reg_two;
							sfs_pkg::OP_RDSR3: tx_d = status_reg_three;
							default: rd_act_d = 1'b0;
						endcase
					end
					2'h1: d1_d = rx_byte;
					2'h2: d2_d = rx_byte;
					default: ;
				endcase
			end
		end
		// Transmit: change on falling sclk; the byte repeats while cs_n stays low
		if (sclk_fall && rd_act_q) begin
			out_d = tx_q[7];
			tx_d = {tx_q[6:0], tx_q[7]};
		end
		// Commands act when cs_n rises after whole bytes
		if (cs_rise) begin
			rd_act_d = 1'b0;
			out_d = 1'b0;
			arm_d = 1'b0;
			if (cmd_done && !busy) begin
				if (cmd_q != sfs_pkg::OP_VWREN && !rd_act_q) begin
					vol_en_d = 1'b0;
				end
				case (cmd_q)
					sfs_pkg::OP_WREN: write_latch_d = 1'b1;
					sfs_pkg::OP_WRDI: write_latch_d = 1'b0;
					sfs_pkg::OP_VWREN: vol_en_d = 1'b1;
					sfs_pkg::OP_RSTEN: arm_d = 1'b1;
					sfs_pkg::OP_RST: begin
						if (arm_q) begin
							sh1_d = nv1_q;
							sh2_d = nv2_q;
							sr3_d = sfs_pkg::SR3_RST;
							write_latch_d = 1'b0;
							vol_en_d = 1'b0;
							op_d = sfs_pkg::SFS_OP_IDLE;
						end
					end
					sfs_pkg::OP_WRSR3: begin
						if (vol_en_q && byte_q >= 2'h2) begin
							sr3_d = d1_q & sfs_pkg::SR3_WR_MASK;
						end
					end
					sfs_pkg::OP_WRSR: begin
						// Refused writes leave the status registers and the write latch alone
						if (byte_q >= 2'h2 && !locked) begin
							if (vol_en_q) begin
								sh1_d = (sh1_q & ~sfs_pkg::SR1_WR_MASK) | (d1_q & sfs_pkg::SR1_WR_MASK);
								if (byte_q == 2'h3) begin
									sh2_d = (sh2_q & ~sfs_pkg::SR2_SH_MASK)
										| (d2_q & sfs_pkg::SR2_SH_MASK);
								end
							end else if (write_latch_q && op_q == sfs_pkg::SFS_OP_IDLE) begin
								pend1_d = d1_q;
								pend2_d = d2_q;
								pend_two_d = (byte_q == 2'h3);
								cnt_d = sfs_pkg::NV_WRITE_CYC - 16'h1;
								op_d = sfs_pkg::SFS_OP_NVW;
							end
						end
					end
					default: ;
				endcase
			end
		end
		// Embedded operation sequencer
		case (op_q)
			sfs_pkg::SFS_OP_IDLE: begin
				if (op_req) begin
					if (write_latch_q && !cs_rise) begin
						op_d = sfs_pkg::SFS_OP_ARR;
						gnt_d = 1'b1;
					end else begin
						ref_d = 1'b1;
					end
				end
			end
			sfs_pkg::SFS_OP_NVW: begin
				cnt_d = cnt_q - 16'h1;
				if (cnt_q == 16'h0) begin
					// Stored cells and shadows update together at the end
					nv1_d = (nv1_q & ~sfs_pkg::SR1_WR_MASK) | (pend1_q & sfs_pkg::SR1_WR_MASK);
					sh1_d = (sh1_q & ~sfs_pkg::SR1_WR_MASK) | (pend1_q & sfs_pkg::SR1_WR_MASK);
					if (pend_two_q) begin
						// Lock bits are one-time: they can be set but never cleared
						nv2_d = (nv2_q & ~sfs_pkg::SR2_WR_MASK) | (pend2_q & sfs_pkg::SR2_WR_MASK)
							| (nv2_q & sfs_pkg::SR2_OTP_MASK) | (pend2_q & sfs_pkg::SR2_OTP_MASK);
						sh2_d = (sh2_q & ~sfs_pkg::SR2_SH_MASK) | (pend2_q & sfs_pkg::SR2_SH_MASK);
					end
					write_latch_d = 1'b0;
					op_d = sfs_pkg::SFS_OP_IDLE;
				end
			end
			sfs_pkg::SFS_OP_ARR: begin
				if (op_done) begin
					write_latch_d = 1'b0;
					op_d = sfs_pkg::SFS_OP_IDLE;
				end else if (suspend_req) begin
					op_d = sfs_pkg::SFS_OP_SUSP;
				end
			end
			sfs_pkg::SFS_OP_SUSP: begin
				if (resume_req) begin
					op_d = sfs_pkg::SFS_OP_ARR;
				end
			end
			default: op_d = sfs_pkg::SFS_OP_IDLE;
		endcase
	end

	// Register update; power-up loads shadows from stored defaults
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			shift_q <= 8'h00;
			cmd_q <= 8'h00;
			d1_q <= 8'h00;
			d2_q <= 8'h00;
			bit_q <= 3'h0;
			byte_q <= 2'h0;
			tx_q <= 8'h00;
			out_q <= 1'b0;
			rd_act_q <= 1'b0;
			nv1_q <= sfs_pkg::SR1_NV_RST;
			nv2_q <= sfs_pkg::SR2_NV_RST;
			sh1_q <= sfs_pkg::SR1_NV_RST;
			sh2_q <= sfs_pkg::SR2_NV_RST;
			sr3_q <= sfs_pkg::SR3_RST;
			pend1_q <= 8'h00;
			pend2_q <= 8'h00;
			pend_two_q <= 1'b0;
			write_latch_q <= 1'b0;
			vol_en_q <= 1'b0;
			arm_q <= 1'b0;
			cnt_q <= 16'h0000;
			op_q <= sfs_pkg::SFS_OP_IDLE;
			gnt_q <= 1'b0;
			ref_q <= 1'b0;
		end else begin
			shift_q <= shift_d;
			cmd_q <= cmd_d;
			d1_q <= d1_d;
			d2_q <= d2_d;
			bit_q <= bit_d;
			byte_q <= byte_d;
			tx_q <= tx_d;
			out_q <= out_d;
			rd_act_q <= rd_act_d;
			nv1_q <= nv1_d;
			nv2_q <= nv2_d;
			sh1_q <= sh1_d;
			sh2_q <= sh2_d;
			sr3_q <= sr3_d;
			pend1_q <= pend1_d;
			pend2_q <= pend2_d;
			pend_two_q <= pend_two_d;
			write_latch_q <= write_latch_d;
			vol_en_q <= vol_en_d;
			arm_q <= arm_d;
			cnt_q <= cnt_d;
			op_q <= op_d;
			gnt_q <= gnt_d;
			ref_q <= ref_d;
		end
	end
endmodule

// ==== hdl/sfs_host.sv ====
// Flash host end: Avalon-MM command registers driving the serial link
`timescale 1ns/1ns
module sfs_host (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Serial link
	sfs_link_if.host lnk
);
	// ****************************************
	// State
	// ****************************************
	sfs_pkg::sfs_hst_e st_q, st_d;
	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d, shift_q, shift_d;
	logic [15:0] txd_q, txd_d;
	logic [1:0] pins_q, pins_d;
	logic [7:0] rx_q, rx_d;
	logic [5:0] nbit_q, nbit_d;
	logic [3:0] div_q, div_d;
	logic sclk_q, sclk_d, cs_n_q, cs_n_d;
	logic miso_s1_q, miso_s2_q;
	logic busy, take;

	assign busy = (st_q != sfs_pkg::SFS_H_IDLE);
	// One wait cycle per access; the access completes on the edge where ack_q is high
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign take = ack_q & (avs_read | avs_write);
	assign avs_readdata = rdata_q;
	// Line 0 data out, line 2 write protect (host drives it only when enabled)
	assign lnk.sclk = sclk_q;
	assign lnk.cs_n = cs_n_q;
	assign lnk.h_o = {1'b1, pins_q[0], 1'b0, shift_q[31]};
	assign lnk.h_oe = {1'b0, pins_q[1], 1'b0, ~cs_n_q};

	// Returned data line from the device crosses in through two flip-flops
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			miso_s1_q <= 1'b0;
			miso_s2_q <= 1'b0;
		end else begin
			miso_s1_q <= lnk.dq[1];
			miso_s2_q <= miso_s1_q;
		end
	end

	// Next-state logic for the bus slave and the serial sequencer
	always_comb begin
		st_d = st_q;
		ack_d = (avs_read | avs_write) & ~ack_q;
		rdata_d = rdata_q;
		shift_d = shift_q;
		txd_d = txd_q;
		pins_d = pins_q;
		rx_d = rx_q;
		nbit_d = nbit_q;
		div_d = div_q;
		sclk_d = sclk_q;
		cs_n_d = cs_n_q;
		// Read data is prepared one edge ahead so it stands when the access completes
		if (ack_d && avs_read) begin
			case (avs_address)
				sfs_pkg::REG_TXDATA: rdata_d = {16'h0000, txd_q};
				sfs_pkg::REG_STATUS: rdata_d = {16'h0000, rx_q, 7'h00, busy};
				sfs_pkg::REG_PINS: rdata_d = {30'h00000000, pins_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
		if (take && avs_write) begin
			case (avs_address)
				sfs_pkg::REG_TXDATA: txd_d = avs_writedata[15:0];
				sfs_pkg::REG_PINS: pins_d = avs_writedata[1:0];
				sfs_pkg::REG_CTRL: begin
					// A start while a transfer runs is dropped
					if (avs_writedata[sfs_pkg::CTRL_GO] && !busy) begin
						shift_d = {avs_writedata[7:0], txd_q, 8'h00};
						nbit_d = 6'(8 * (1 + avs_writedata[sfs_pkg::CTRL_NTX_HI:sfs_pkg::CTRL_NTX_LO]
							+ avs_writedata[sfs_pkg::CTRL_READ]));
						cs_n_d = 1'b0;
						div_d = 4'h0;
						st_d = sfs_pkg::SFS_H_SEL;
					end
				end
				default: ;
			endcase
		end
		case (st_q)
			sfs_pkg::SFS_H_IDLE: ;
			sfs_pkg::SFS_H_SEL: begin
				div_d = div_q + 4'h1;
				if (div_q == sfs_pkg::SCLK_HALF_CYC - 4'h1) begin
					div_d = 4'h0;
					st_d = sfs_pkg::SFS_H_SHIFT;
				end
			end
			sfs_pkg::SFS_H_SHIFT: begin
				div_d = div_q + 4'h1;
				if (div_q == sfs_pkg::SCLK_HALF_CYC - 4'h1) begin
					div_d = 4'h0;
					sclk_d = ~sclk_q;
					if (sclk_q) begin
						// End of high phase: capture returned bit, advance output bit
						rx_d = {rx_q[6:0], miso_s2_q};
						shift_d = {shift_q[30:0], 1'b0};
						nbit_d = nbit_q - 6'h1;
						if (nbit_q == 6'h1) begin
							st_d = sfs_pkg::SFS_H_DESEL;
						end
					end
				end
			end
			sfs_pkg::SFS_H_DESEL: begin
				cs_n_d = 1'b1;
				div_d = div_q + 4'h1;
				if (div_q == sfs_pkg::CS_IDLE_CYC - 4'h1) begin
					div_d = 4'h0;
					st_d = sfs_pkg::SFS_H_IDLE;
				end
			end
			default: st_d = sfs_pkg::SFS_H_IDLE;
		endcase
	end

	// Register update
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= sfs_pkg::SFS_H_IDLE;
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
			shift_q <= 32'h00000000;
			txd_q <= 16'h0000;
			pins_q <= 2'h0;
			rx_q <= 8'h00;
			nbit_q <= 6'h00;
			div_q <= 4'h0;
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			st_q <= st_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			shift_q <= shift_d;
			txd_q <= txd_d;
			pins_q <= pins_d;
			rx_q <= rx_d;
			nbit_q <= nbit_d;
			div_q <= div_d;
			sclk_q <= sclk_d;
			cs_n_q <= cs_n_d;
		end
	end
endmodule

// ==== testbench/sfs_link_sva.sv ====
// Link protocol checker for the flash host and device pair
`timescale 1ns/1ns
module sfs_link_sva (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Link signals
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] h_o,
	input wire logic [3:0] h_oe,
	input wire logic [3:0] d_o,
	input wire logic [3:0] d_oe,
	input wire logic [3:0] dq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Host drives its data line exactly while the device is selected
	property p_hsel;
		h_oe[0] == !cs_n;
	endproperty
	a_hsel: assert property (p_hsel) else $error("host data enable outside frame");
	// Device releases its line once deselect has passed its two-stage synchroniser
	property p_dquiet;
		cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) |-> d_oe == 4'h0;
	endproperty
	a_dquiet: assert property (p_dquiet) else $error("device drives while idle");
	// Device answers on one line only
	property p_dlines;
		d_oe[3:2] == 2'h0 && !d_oe[0];
	endproperty
	a_dlines: assert property (p_dlines) else $error("device drives wrong line");
	// Host never drives the answer line or line three
	property p_hlines;
		!h_oe[1] && !h_oe[3];
	endproperty
	a_hlines: assert property (p_hlines) else $error("host drives reserved line");
	// Clock rests low between frames
	property p_idle;
		cs_n |-> !sclk;
	endproperty
	a_idle: assert property (p_idle) else $error("link clock moves while idle");
	// High half of the link clock lasts four cycles
	property p_half;
		$rose(sclk) |-> sclk [*4] ##1 !sclk;
	endproperty
	a_half: assert property (p_half) else $error("link clock high phase wrong");
	// Select leads the first clock rise by four cycles at least
	property p_lead;
		$fell(cs_n) |-> !sclk [*4];
	endproperty
	a_lead: assert property (p_lead) else $error("select lead too short");
	// Deselect gap between frames of eight cycles at least
	property p_gap;
		$rose(cs_n) |-> cs_n [*8];
	endproperty
	a_gap: assert property (p_gap) else $error("deselect gap too short");
endmodule

// ==== testbench/tb_spi_flash_status_registers.sv ====
// Self-checking bench for the flash host and status device pair
`timescale 1ns/1ns
module tb_spi_flash_status_registers;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] eng = 4'h0;
	logic [31:0] rdat, r;
	logic wait_r, og, orf, qio, pg, plo, pn, ipm, we;
	logic [7:0] sr1, sr2, sr3;
	logic [2:0] pr;
	logic [6:0] wb;
	int bad_count = 0;
	int n_checks = 0;
	// Clock, half period of 10 ns
	always #10 clk_sys = ~clk_sys;
	// ****
	// Design pair and checker
	// ****
	sfs_link_if i_sfs_link_if ();
	sfs_host i_sfs_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(wait_r), .lnk(i_sfs_link_if.host));
	sfs_dev i_sfs_dev (.clk_sys(clk_sys), .sys_rst(sys_rst), .lnk(i_sfs_link_if.device),
		.op_req(eng[0]), .op_done(eng[1]), .suspend_req(eng[2]), .resume_req(eng[3]),
		.op_granted(og), .op_refused(orf), .status_reg_one(sr1), .status_reg_two(sr2),
		.status_reg_three(sr3), .quad_io_on(qio), .protect_granularity(pg),
		.protect_from_low_end(plo), .protect_range(pr), .protect_none(pn),
		.invert_protect_map(ipm), .wrap_bytes(wb), .wrap_enable(we));
	sfs_link_sva i_sfs_link_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.sclk(i_sfs_link_if.sclk), .cs_n(i_sfs_link_if.cs_n), .h_o(i_sfs_link_if.h_o),
		.h_oe(i_sfs_link_if.h_oe), .d_o(i_sfs_link_if.d_o), .d_oe(i_sfs_link_if.d_oe),
		.dq(i_sfs_link_if.dq));
	// ****
	// Tasks
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One Avalon access, held until waitrequest is seen low
	task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk_sys); while (wait_r !== 1'b0);
		r = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	// Send a frame, poll until the host is idle, then allow for link sync
	task automatic cmd(input logic [7:0] c, input logic [1:0] n, input logic [15:0] tx,
		input logic rb);
		if (n != 2'h0) av(1'b1, sfs_pkg::REG_TXDATA, {16'h0, tx});
		av(1'b1, sfs_pkg::REG_CTRL, {1'b1, 20'h0, rb, n, c});
		do av(1'b0, sfs_pkg::REG_STATUS, 32'h0); while (r[0] !== 1'b0);
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic op(input logic [7:0] c);
		cmd(c, 2'h0, 16'h0, 1'b0);
	endtask
	// Single data byte sits in both halves so either send order works
	task automatic cmd1(input logic [7:0] c, input logic [7:0] b);
		cmd(c, 2'h1, {b, b}, 1'b0);
	endtask
	task automatic pulse(input logic [3:0] v);
		@(posedge clk_sys);
		eng <= v;
		@(posedge clk_sys);
		eng <= 4'h0;
		#1;
	endtask
	task automatic wait_nv;
		for (int i = 0; i < 700 && sr1[0] !== 1'b0; i++) @(posedge clk_sys);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Watchdog, far beyond the expected run of some 5k cycles
	initial begin
		#1000000;
		bad_count++;
		complete_run;
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		chk({sr1, sr2}, 16'h0004);
		chk({sr3, pn, we, wb}, {8'h70, 1'b1, 1'b0, 7'h40});
		cmd(sfs_pkg::OP_RDSR3, 2'h0, 16'h0, 1'b1);
		chk(r[15:8], 8'h70);
		av(1'b0, 5'h10, 32'h0);
		chk(r, 32'h0);
		$display("test reset done");
		cmd1(sfs_pkg::OP_WRSR, 8'h1C);
		chk(sr1, 8'h00);
		op(sfs_pkg::OP_WREN);
		cmd(sfs_pkg::OP_RDSR1, 2'h0, 16'h0, 1'b1);
		chk(r[15:8], 8'h02);
		cmd(sfs_pkg::OP_WRSR, 2'h2, 16'h3C02, 1'b0);
		chk(sr1[1:0], 2'h3);
		wait_nv;
		chk({sr1, sr2}, 16'h3C06);
		chk({qio, plo, pr, pg}, 6'h3E);
		$display("test stored write done");
		op(sfs_pkg::OP_VWREN);
		cmd1(sfs_pkg::OP_WRSR, 8'h40);
		chk({sr1[7:2], sr1[0], pg, pn}, {6'h10, 3'h3});
		op(sfs_pkg::OP_RST);
		chk(sr1, 8'h40);
		op(sfs_pkg::OP_RSTEN);
		op(sfs_pkg::OP_RST);
		chk({sr1, sr3}, 16'h3C70);
		for (int c = 0; c < 4; c++) begin
			op(sfs_pkg::OP_VWREN);
			cmd1(sfs_pkg::OP_WRSR3, 8'(c << 5));
			chk({sr3, we, wb}, {8'(c << 5), 1'b1, 7'(8 << c)});
		end
		$display("test shadow write done");
		op(sfs_pkg::OP_WREN);
		cmd(sfs_pkg::OP_WRSR, 2'h2, 16'hBC00, 1'b0);
		wait_nv;
		chk({sr1, sr2}, 16'hBC04);
		av(1'b1, sfs_pkg::REG_PINS, 32'h2);
		op(sfs_pkg::OP_VWREN);
		cmd1(sfs_pkg::OP_WRSR, 8'h80);
		chk(sr1, 8'hBC);
		op(sfs_pkg::OP_VWREN);
		cmd1(sfs_pkg::OP_WRSR3, 8'h10);
		chk(sr3, 8'h10);
		av(1'b1, sfs_pkg::REG_PINS, 32'h3);
		op(sfs_pkg::OP_VWREN);
		cmd1(sfs_pkg::OP_WRSR, 8'h80);
		chk(sr1, 8'h80);
		op(sfs_pkg::OP_VWREN);
		cmd(sfs_pkg::OP_WRSR, 2'h2, 16'h8042, 1'b0);
		chk({ipm, qio, sr2}, {1'b1, 1'b1, 8'h46});
		av(1'b1, sfs_pkg::REG_PINS, 32'h2);
		op(sfs_pkg::OP_VWREN);
		cmd(sfs_pkg::OP_WRSR, 2'h2, 16'h8C42, 1'b0);
		chk({sr1, ipm}, {8'h8C, 1'b1});
		$display("test lock done");
		pulse(4'h1);
		chk({og, orf}, 2'h1);
		op(sfs_pkg::OP_WREN);
		pulse(4'h1);
		chk({og, orf, sr1[1:0]}, 4'hB);
		pulse(4'h4);
		chk(sr2[7], 1'b1);
		pulse(4'h8);
		chk(sr2[7], 1'b0);
		pulse(4'h2);
		chk(sr1[1:0], 2'h0);
		$display("test engine done");
		complete_run;
	end
endmodule
